// File: logic/ufr_pkg.sv
// ufr_pkg: constants and carrier types of the uart receive timeout block.
// assumes: a 50 MHz system clock and 32-bit AHB-Lite register access.
package ufr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] CTRL_INDEX = 10'h0_0F0;  // control bits
  localparam logic [9:0] STAT_INDEX = 10'h0_0F1;  // sticky events, w1c
  localparam logic [9:0] MASK_INDEX = 10'h0_0F2;  // event mask
  localparam logic [9:0] FCT_INDEX = 10'h0_0FA;  // fifo fill counts

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_RESET = 12'h0_A01;  // 10-bit chars, irq enable on
  localparam logic [2:0] MASK_RESET = 3'h0;  // all events masked
  localparam logic [2:0] STAT_RESET = 3'h0;  // no events pending

  // ----------------------------------------------------------------
  // idle timeout lengths in character periods
  // ----------------------------------------------------------------
  localparam logic [4:0] IDLE_PERIODS_SEL1 = 5'h02;
  localparam logic [4:0] IDLE_PERIODS_SEL2 = 5'h04;
  localparam logic [4:0] IDLE_PERIODS_SEL3 = 5'h10;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  // control register layout, bit 0 first from the right
  typedef struct packed {
    logic [3:0] charBits;  // bits per character on the line
    logic reserved7;
    logic [2:0] rxFifoThreshold;  // receive threshold
    logic reserved3;
    logic [1:0] rxIdleTimeoutSel;  // idle timeout select
    logic rxIrqEnable;  // receive flag interrupt enable
  } ufr_ctrl_type;

  // event bits, shared by status and mask
  typedef struct packed {
    logic timeoutEvent;  // timeout request raised
    logic requestEvent;  // fifo request raised
    logic rxFlagEvent;  // receive data became present
  } ufr_event_type;

  // fifo occupancy reported by the byte fifos
  typedef struct packed {
    logic [2:0] txFillCount;
    logic [2:0] rxFillCount;
  } ufr_fill_type;

  // idle periods needed for a timeout select value
  function automatic logic [4:0] ufr_idle_need(input logic [1:0] sel);
    unique case (sel)
      2'h1: ufr_idle_need = IDLE_PERIODS_SEL1;
      2'h2: ufr_idle_need = IDLE_PERIODS_SEL2;
      2'h3: ufr_idle_need = IDLE_PERIODS_SEL3;
      2'h0: ufr_idle_need = 5'h00;
    endcase
  endfunction : ufr_idle_need

endpackage : ufr_pkg

// File: logic/ufr_rx_timeout.sv
// ufr_rx_timeout: receive idle timeout, receive interrupt gate and fifo counts.
// assumes: bitTick is a one-cycle pulse per bit time on clk; the fifos report
// their fill counts on clk; rxLine is an asynchronous pin.
//
// Functional notes
// [R1] select zero never raises idle requests
// [R2] selects one to three: 2, 4, 16
// [R3] timeout request when idle with data at or under threshold
// [R4] one idle period equals one character
// [R5] enabled receive flag reaches uart interrupt
// [R6] disabled receive flag never interrupts
// [R7] receive flag fires on any fifo data
// [R8] bits six to four show tx count
// [R9] bits two to zero show rx count
// [R10] request set while count exceeds threshold
// [R11] idle count restarts on start, empty
// [R12] timeout request holds until empty or above
module ufr_rx_timeout
  import ufr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxLine,
  input wire logic bitTick,
  input wire ufr_pkg::ufr_fill_type fill,
  output logic rxFifoRequest,
  output logic uartIrq
);
  import ufr_pkg::*;

  // ----------------------------------------------------------------
  // receive line synchroniser
  // ----------------------------------------------------------------
  logic [2:0] rxSync;  // three-stage pin chain
  logic rxLevel;  // accepted line level
  logic [2:0] next_rxSync;
  logic next_rxLevel;
  logic startBit;  // falling edge of accepted level

  // shift in, accept a level once stages two and three agree
  always_comb begin
    next_rxSync = {rxSync[1:0], rxLine};
    next_rxLevel = (rxSync[1] == rxSync[2]) ? rxSync[2] : rxLevel;
    startBit = rxLevel && !next_rxLevel;
  end

  // idle line resets high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSync <= 3'h7;
      rxLevel <= 1'b1;
    end else begin
      rxSync <= next_rxSync;
      rxLevel <= next_rxLevel;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  ufr_ctrl_type ctrl, next_ctrl;  // software control
  ufr_event_type stat, next_stat;  // sticky events
  ufr_event_type mask, next_mask;  // event mask
  logic rxFlag;  // receive data present
  logic timeoutReq;  // timeout request held
  logic countAbove;  // count above threshold, registered
  logic next_rxFlag;
  logic next_timeoutReq;
  logic next_countAbove;

  // ----------------------------------------------------------------
  // idle period timer
  // ----------------------------------------------------------------
  logic [3:0] bitCnt, next_bitCnt;  // bit times within a period
  logic [4:0] idlePeriods, next_idlePeriods;  // whole idle periods
  logic fifoEmpty;
  logic fifoAbove;
  logic [4:0] idleNeed;

  // count bit times while the line idles with data waiting
  always_comb begin
    fifoEmpty = (fill.rxFillCount == 3'h0);
    fifoAbove = (fill.rxFillCount > ctrl.rxFifoThreshold);
    idleNeed = ufr_idle_need(ctrl.rxIdleTimeoutSel);
    next_bitCnt = bitCnt;
    next_idlePeriods = idlePeriods;
    if (startBit || fifoEmpty) begin  // see [R11]
      next_bitCnt = 4'h0;
      next_idlePeriods = 5'h00;
    end else if (bitTick && rxLevel) begin
      // a period ends after one full character of bit times, see [R4]
      if (bitCnt >= ctrl.charBits - 4'h1) begin
        next_bitCnt = 4'h0;
        if (idlePeriods != IDLE_PERIODS_SEL3) begin  // saturate
          next_idlePeriods = idlePeriods + 5'h01;
        end
      end else begin
        next_bitCnt = bitCnt + 4'h1;
      end
    end
  end

  // timer flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt <= 4'h0;
      idlePeriods <= 5'h00;
    end else begin
      bitCnt <= next_bitCnt;
      idlePeriods <= next_idlePeriods;
    end
  end

  // ----------------------------------------------------------------
  // request and flag logic
  // ----------------------------------------------------------------
  // timeout request raises on enough idle periods, holds until drained or above threshold
  always_comb begin
    next_timeoutReq = timeoutReq;
    if (ctrl.rxIdleTimeoutSel == 2'h0) begin  // see [R1]
      next_timeoutReq = 1'b0;
    end else if (fifoEmpty || fifoAbove) begin  // see [R12]
      next_timeoutReq = 1'b0;
    end else if (idlePeriods >= idleNeed) begin  // see [R2] [R3]
      next_timeoutReq = 1'b1;
    end
    next_countAbove = fifoAbove;  // see [R10]
    next_rxFlag = !fifoEmpty;  // see [R7]
  end

  // flag flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeoutReq <= 1'b0;
      countAbove <= 1'b0;
      rxFlag <= 1'b0;
    end else begin
      timeoutReq <= next_timeoutReq;
      countAbove <= next_countAbove;
      rxFlag <= next_rxFlag;
    end
  end

  // ----------------------------------------------------------------
  // bus slave, zero wait states
  // ----------------------------------------------------------------
  logic dataWrite;  // data phase of a write pending
  logic [9:0] dataIndex;  // register index of that write
  logic next_dataWrite;
  logic [9:0] next_dataIndex;
  logic addrValid;  // address phase taken this cycle
  logic addrMapped;
  logic [31:0] next_hrdata;
  ufr_event_type rise;  // events seen this cycle
  logic [2:0] clearBits;  // written ones on status
  logic next_uartIrq;
  logic next_rxFifoRequest;

  // decode, register updates, read mux and interrupt
  always_comb begin
    addrValid = hsel && hready && htrans[1];
    addrMapped = (haddr[31:12] == 20'h0_0000);
    // writes outside the register window are dropped, like reads
    next_dataWrite = addrValid && hwrite && addrMapped;
    next_dataIndex = addrValid ? haddr[11:2] : dataIndex;
    next_ctrl = ctrl;
    next_mask = mask;
    clearBits = 3'h0;
    if (dataWrite) begin
      unique case (dataIndex)
        CTRL_INDEX: next_ctrl = ufr_ctrl_type'(hwdata[11:0] & 12'h0_F77);
        MASK_INDEX: next_mask = ufr_event_type'(hwdata[2:0]);
        STAT_INDEX: clearBits = hwdata[2:0];
        default: ;  // unmapped or read-only: ignored
      endcase
    end
    rise.rxFlagEvent = next_rxFlag && !rxFlag;
    rise.requestEvent = next_countAbove && !countAbove;
    rise.timeoutEvent = next_timeoutReq && !timeoutReq;
    // a new event wins over a clear in the same cycle
    next_stat = ufr_event_type'((stat & ~clearBits) | rise);
    next_hrdata = 32'h0000_0000;
    if (addrValid && !hwrite && addrMapped) begin
      unique case (haddr[11:2])
        CTRL_INDEX: next_hrdata = {20'h0_0000, next_ctrl};
        MASK_INDEX: next_hrdata = {29'h0000_0000, next_mask};
        STAT_INDEX: next_hrdata = {22'h00_0000, next_timeoutReq, next_countAbove,
                                   5'h00, next_stat};
        // see [R8] [R9]
        FCT_INDEX: next_hrdata = {25'h000_0000, fill.txFillCount, 1'b0,
                                  fill.rxFillCount};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
    // receive flag passes only with its enable, see [R5] [R6]
    next_uartIrq = (next_stat.rxFlagEvent && next_mask.rxFlagEvent
                    && next_ctrl.rxIrqEnable)
                   || (next_stat.requestEvent && next_mask.requestEvent)
                   || (next_stat.timeoutEvent && next_mask.timeoutEvent);
    next_rxFifoRequest = next_countAbove || next_timeoutReq;  // see [R3] [R10]
  end

  // register and bus flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= ufr_ctrl_type'(CTRL_RESET);
      mask <= ufr_event_type'(MASK_RESET);
      stat <= ufr_event_type'(STAT_RESET);
      dataWrite <= 1'b0;
      dataIndex <= 10'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      uartIrq <= 1'b0;
      rxFifoRequest <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      stat <= next_stat;
      dataWrite <= next_dataWrite;
      dataIndex <= next_dataIndex;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      uartIrq <= next_uartIrq;
      rxFifoRequest <= next_rxFifoRequest;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sel_zero_quiet: assert property (ctrl.rxIdleTimeoutSel == 2'h0 |=> !timeoutReq) // see [R1]
    else $error("timeout request with timeout disabled");

  // raise path: flag and output both load on the edge after the count is reached
  a_timeout_raise: assert property ((ctrl.rxIdleTimeoutSel != 2'h0) && !fifoEmpty // see [R3]
      && !fifoAbove && !startBit && (idlePeriods >= ufr_idle_need(ctrl.rxIdleTimeoutSel))
      |=> timeoutReq && rxFifoRequest)
    else $error("timeout request not raised");

  a_timeout_early: assert property (!timeoutReq && (idlePeriods < idleNeed) // see [R2]
      |=> !timeoutReq)
    else $error("timeout request before idle periods elapsed");

  a_period_length: assert property (bitTick && rxLevel && !startBit && !fifoEmpty // see [R4]
      && (bitCnt == ctrl.charBits - 4'h1) && (idlePeriods < IDLE_PERIODS_SEL3)
      |=> (bitCnt == 4'h0) && (idlePeriods == $past(idlePeriods) + 5'h01))
    else $error("idle period length wrong");

  a_irq_enabled: assert property ($rose(rxFlag) && ctrl.rxIrqEnable // see [R5] [R7]
      && mask.rxFlagEvent && $stable(ctrl) && $stable(mask) && !dataWrite |=> uartIrq)
    else $error("receive flag did not interrupt");

  // registered interrupt matches the registered enable, status and mask
  a_irq_disabled: assert property (!ctrl.rxIrqEnable // see [R6]
      && !(stat.requestEvent && mask.requestEvent)
      && !(stat.timeoutEvent && mask.timeoutEvent) |-> !uartIrq)
    else $error("interrupt with receive enable off");

  a_fill_read: assert property (addrValid && !hwrite // see [R8] [R9]
      && (haddr == {20'h0_0000, FCT_INDEX, 2'h0}) |=> (hrdata[6:4] == $past(fill.txFillCount))
      && (hrdata[2:0] == $past(fill.rxFillCount)) && (hrdata[7] == 1'b0))
    else $error("fill count read wrong");

  a_count_request: assert property (fifoAbove |=> countAbove && rxFifoRequest) // see [R10]
    else $error("request missing above threshold");

  a_idle_restart: assert property (startBit || fifoEmpty // see [R11]
      |=> (idlePeriods == 5'h00) && (bitCnt == 4'h0))
    else $error("idle count not restarted");

  a_timeout_hold: assert property (timeoutReq && !fifoEmpty && !fifoAbove // see [R12]
      && (ctrl.rxIdleTimeoutSel != 2'h0) |=> timeoutReq)
    else $error("timeout request dropped early");

  // synchroniser: accepted level follows once stages two and three agree
  a_line_accept: assert property ((rxSync[1] == rxSync[2]) // see [R11]
      |=> (rxLevel == $past(rxSync[2])))
    else $error("line level not accepted");

  a_line_hold: assert property ((rxSync[1] != rxSync[2]) |=> $stable(rxLevel)) // see [R11]
    else $error("line level moved on disagreement");

  // receive flag is a level of fifo data, its event a sticky bit
  a_flag_level: assert property (!fifoEmpty |=> rxFlag) // see [R7]
    else $error("receive flag missing with data");

  a_flag_sticky: assert property ($rose(rxFlag) |-> stat.rxFlagEvent) // see [R7]
    else $error("receive flag event not recorded");

  // request output drops once the fifo drains; count request drops once the count falls
  a_request_empty: assert property (fifoEmpty |=> !rxFifoRequest) // see [R12]
    else $error("request held with empty fifo");

  a_count_clear: assert property (!fifoAbove |=> !countAbove) // see [R10]
    else $error("count request without excess data");

endmodule : ufr_rx_timeout

// File: bench/ufr_line_sender.sv
// ufr_line_sender: remote serial transmitter on the receive line.
// assumes: bitTick is the bit-time pulse the block also sees.
module ufr_line_sender (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bitTick,
  input wire logic sendStart,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ns;
  logic inStart;  // start bit on the line
  // start bit lasts up to the next bit tick; data and stop bits are ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inStart <= 1'b0;
    end else if (sendStart) begin
      inStart <= 1'b1;
    end else if (bitTick) begin
      inStart <= 1'b0;
    end
  end
  assign rxLine = ~inStart;  // idle high between frames (pull-up level)
endmodule : ufr_line_sender

// File: bench/test_uart_fifo_rx_timeout_count.sv
// test_uart_fifo_rx_timeout_count: self-checking bench of the rx timeout block.
// assumes: zero-wait AHB-Lite slave; one clock; fifo counts driven here.
module test_uart_fifo_rx_timeout_count;
  timeunit 1ns;
  timeprecision 1ns;
  import ufr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic bitTick = 1'b0, sendStart = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdSeen, rd;
  ufr_fill_type fill = 6'h00;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, rxLine, rxFifoRequest, uartIrq;
  int numErrors = 0, checksDone = 0;
  initial forever #10 clk = ~clk;
  always @(posedge clk) hrdSeen <= hrdata;  // value held up to this edge
  ufr_rx_timeout dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rxLine(rxLine), .bitTick(bitTick), .fill(fill),
    .rxFifoRequest(rxFifoRequest), .uartIrq(uartIrq));
  ufr_line_sender far (.clk(clk), .rst_n(rst_n), .bitTick(bitTick),
    .sendStart(sendStart), .rxLine(rxLine));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stopTest;
    $display("errors %0d checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stopTest
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one single AHB transfer; read data lands in rd
  task bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0_0000, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    #1 rd = hrdSeen;
  endtask : bus
  task ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      bitTick <= 1'b1;
      @(posedge clk);
      bitTick <= 1'b0;
    end
  endtask : ticks
  task setRx(input logic [2:0] n);
    @(posedge clk);
    fill.rxFillCount <= n;
    cyc(2);
  endtask : setRx
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task resetAndCounts;
    @(posedge clk);
    fill <= 6'b101_011;
    cyc(3);
    chk("hreadyout idle", 32'h1, hreadyout);
    chk("hresp okay", 32'h0, hresp);
    bus(1'b0, CTRL_INDEX, 32'h0000_0000);
    chk("ctrl reset", {20'h0_0000, CTRL_RESET}, rd);
    bus(1'b0, MASK_INDEX, 32'h0000_0000);
    chk("mask reset", 32'h0000_0000, rd);
    bus(1'b0, FCT_INDEX, 32'h0000_0000);
    chk("fill counts", 32'h0000_0053, rd);
    bus(1'b0, 10'h040, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    chk("request above zero", 32'h1, rxFifoRequest);
    chk("irq masked", 32'h0, uartIrq);
    chk("hresp after reads", 32'h0, hresp);
    bus(1'b1, STAT_INDEX, 32'h0000_0007);
  endtask : resetAndCounts
  task countAbove;
    bus(1'b1, CTRL_INDEX, 32'h0000_0A31);
    setRx(3'h3);
    chk("request at threshold", 32'h0, rxFifoRequest);
    setRx(3'h4);
    chk("request above", 32'h1, rxFifoRequest);
  endtask : countAbove
  task idleTimeout(input logic [1:0] sel, input int periods);
    setRx(3'h0);
    bus(1'b1, CTRL_INDEX, 32'h0000_0A30 | {29'h0, sel, 1'b0});
    setRx(3'h1);
    ticks(periods * 10 - 1);
    cyc(3);
    chk("timeout early", 32'h0, rxFifoRequest);
    ticks(1);
    cyc(3);
    chk("timeout", sel != 2'h0, rxFifoRequest);
    ticks(3);
    chk("timeout held", sel != 2'h0, rxFifoRequest);
    setRx(3'h0);
    chk("timeout cleared", 32'h0, rxFifoRequest);
  endtask : idleTimeout
  task startRestart;
    bus(1'b1, CTRL_INDEX, 32'h0000_0A32);
    setRx(3'h1);
    ticks(15);
    setRx(3'h0);
    setRx(3'h1);
    ticks(15);
    @(posedge clk);
    sendStart <= 1'b1;
    @(posedge clk);
    sendStart <= 1'b0;
    cyc(6);
    ticks(1);
    cyc(6);
    ticks(19);
    cyc(3);
    chk("restart early", 32'h0, rxFifoRequest);
    ticks(1);
    cyc(3);
    chk("restart timeout", 32'h1, rxFifoRequest);
    setRx(3'h0);
  endtask : startRestart
  task irqGate;
    bus(1'b1, CTRL_INDEX, 32'h0000_0A71);
    bus(1'b1, STAT_INDEX, 32'h0000_0007);
    bus(1'b1, MASK_INDEX, 32'h0000_0001);
    cyc(2);
    chk("irq before data", 32'h0, uartIrq);
    setRx(3'h1);
    cyc(2);
    chk("irq on data", 32'h1, uartIrq);
    bus(1'b0, STAT_INDEX, 32'h0000_0000);
    chk("status flag", 32'h0000_0001, rd);
    bus(1'b1, STAT_INDEX, 32'h0000_0001);
    cyc(2);
    chk("irq cleared", 32'h0, uartIrq);
    bus(1'b1, CTRL_INDEX, 32'h0000_0A70);
    setRx(3'h0);
    setRx(3'h2);
    cyc(2);
    chk("irq disabled", 32'h0, uartIrq);
    bus(1'b1, STAT_INDEX, 32'h0000_0007);
  endtask : irqGate
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    resetAndCounts();
    countAbove();
    idleTimeout(2'h0, 4);
    idleTimeout(2'h1, 2);
    idleTimeout(2'h2, 4);
    idleTimeout(2'h3, 16);
    startRestart();
    irqGate();
    stopTest();
  end
  initial begin
    #200us;
    numErrors++;
    $display("ERROR watchdog expected done seen hang");
    stopTest();
  end
endmodule : test_uart_fifo_rx_timeout_count
